//--- inc/bcc_pkg.sv
package bcc_pkg;
  // ------------------------------------------------------------
  // counter geometry
  // ------------------------------------------------------------
  localparam int BCC_CNT_W     = 11;
  localparam int BCC_LSB_W     = 3;
  localparam int BCC_STAGE_W   = 4;
  localparam int BCC_BYTE_W    = 8;
  localparam int BCC_HI_USED_W = 3;
  // ------------------------------------------------------------
  // reset values and marks
  // ------------------------------------------------------------
  localparam logic [7:0]  BCC_BYTE_RST  = 8'h00;
  localparam logic [10:0] BCC_CNT_RST   = 11'h000;
  localparam logic [10:0] BCC_CNT_ONE   = 11'h001;
  localparam logic [2:0]  BCC_LSB_ONE   = 3'h1;
  localparam logic [3:0]  BCC_STAGE_RST = 4'h0;
  localparam logic [3:0]  BCC_STAGE_MAX = 4'hf;

  typedef enum logic [1:0] {
    BCC_IDLE,
    BCC_STANDBY,
    BCC_COUNT,
    BCC_DONE
  } bcc_state_t;
endpackage

//--- rtl/bcc_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// one 4-bit down-counter stage with preset and terminal count
// ------------------------------------------------------------
module bcc_stage
  import bcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [3:0] preset,
  input  wire logic       enable,
  input  wire logic       borrow_in,
  output logic [3:0]      value_reg,
  output logic            zero
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= BCC_STAGE_RST;
    end else if (load) begin
      value_reg <= preset;
    end else if (enable && borrow_in) begin
      value_reg <= value_reg - 4'h1;
    end
  end

  assign zero = (value_reg == BCC_STAGE_RST);
endmodule
`default_nettype wire

//--- rtl/bcc_burst_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bcc_burst_ctrl
  import bcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] data_in,
  input  wire logic       burst_low_byte_strobe_n,
  input  wire logic       burst_high_byte_strobe_n,
  input  wire logic       counter_load_strobe_n,
  input  wire logic       ext_trigger,
  input  wire logic       manual_trigger_key,
  input  wire logic       period_pulse,
  output logic            burst_clock_en_reg,
  output logic            burst_on_n_reg,
  output logic            blocking_reg,
  output logic            counter_enable_reg,
  output logic [10:0]     count_reg
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] prev_reg;
  logic [6:0] raw_in;

  assign raw_in = {period_pulse, manual_trigger_key, ext_trigger,
                   counter_load_strobe_n, burst_high_byte_strobe_n,
                   burst_low_byte_strobe_n, 1'b0};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 7'h0e;
      sync2_reg <= 7'h0e;
      prev_reg  <= 7'h0e;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // data bus is stable around the strobe, two flops keep it clean
  logic [7:0] data_s1_reg;
  logic [7:0] data_s2_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_reg <= BCC_BYTE_RST;
      data_s2_reg <= BCC_BYTE_RST;
    end else begin
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  // strobes act on their falling edge, like the latch enables
  logic lo_fall;
  logic hi_fall;
  logic load_fall;
  logic trig_rise;
  logic pulse_rise;
  assign lo_fall    = prev_reg[1] & ~sync2_reg[1];
  assign hi_fall    = prev_reg[2] & ~sync2_reg[2];
  assign load_fall  = prev_reg[3] & ~sync2_reg[3];
  assign trig_rise  = (~prev_reg[4] & sync2_reg[4]) |
                      (~prev_reg[5] & sync2_reg[5]);
  assign pulse_rise = ~prev_reg[6] & sync2_reg[6];

  // ------------------------------------------------------------
  // burst number acceptors
  // ------------------------------------------------------------
  logic [7:0] low_byte_reg;
  logic [7:0] high_byte_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_byte_reg  <= BCC_BYTE_RST;
      high_byte_reg <= BCC_BYTE_RST;
    end else begin
      if (lo_fall) begin
        low_byte_reg <= data_s2_reg;
      end
      if (hi_fall) begin
        high_byte_reg <= data_s2_reg;
      end
    end
  end

  logic [10:0] preset;
  assign preset = {high_byte_reg[2:0], low_byte_reg};

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  bcc_state_t state_reg;
  logic       tick;
  logic       at_one;
  assign at_one = (count_reg == BCC_CNT_ONE);
  // only pulses while burst is active clock the counter
  assign tick = (state_reg == BCC_COUNT) && pulse_rise
                && burst_clock_en_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BCC_IDLE;
    end else if (load_fall) begin
      state_reg <= BCC_STANDBY;
    end else begin
      case (state_reg)
        BCC_IDLE:    state_reg <= BCC_IDLE;
        BCC_STANDBY: begin
          if (trig_rise) begin
            state_reg <= BCC_COUNT;
          end
        end
        BCC_COUNT: begin
          if (tick && at_one) begin
            state_reg <= BCC_DONE;
          end
        end
        BCC_DONE:    state_reg <= BCC_DONE;
        default:     state_reg <= BCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_enable_reg <= 1'b0;
    end else if (load_fall) begin
      counter_enable_reg <= 1'b0;
    end else begin
      counter_enable_reg <= (state_reg == BCC_COUNT);
    end
  end

  // ------------------------------------------------------------
  // counter: three low flops plus two cascaded stages
  // ------------------------------------------------------------
  logic [2:0] lsb_reg;
  logic [3:0] mid_val;
  logic [3:0] top_val;
  logic       mid_zero;
  logic       top_zero;
  logic       lsb_borrow;
  assign lsb_borrow = (lsb_reg == 3'h0);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsb_reg <= 3'h0;
    end else if (load_fall) begin
      lsb_reg <= preset[2:0];
    end else if (tick) begin
      lsb_reg <= lsb_reg - 3'h1;
    end
  end

  bcc_stage u_mid (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .load      (load_fall),
    .preset    (preset[6:3]),
    .enable    (tick),
    .borrow_in (lsb_borrow),
    .value_reg (mid_val),
    .zero      (mid_zero)
  );

  // upper stage is held off once the blocking flop is set
  bcc_stage u_top (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .load      (load_fall),
    .preset    (preset[10:7]),
    .enable    (tick && !blocking_reg),
    .borrow_in (lsb_borrow && mid_zero),
    .value_reg (top_val),
    .zero      (top_zero)
  );

  assign count_reg = {top_val, mid_val, lsb_reg};

  // ------------------------------------------------------------
  // blocking flop and burst-active line
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocking_reg <= 1'b0;
    end else if (load_fall) begin
      blocking_reg <= 1'b0;
    end else if (mid_zero && top_zero && state_reg == BCC_COUNT) begin
      blocking_reg <= 1'b1;
    end
  end

  // burst clock enable stays set until the last pulse at count one, then burst_on_n goes low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_clock_en_reg <= 1'b0;
      burst_on_n_reg     <= 1'b1;
    end else if (load_fall) begin
      burst_clock_en_reg <= 1'b0;
      burst_on_n_reg     <= 1'b1;
    end else if (state_reg == BCC_STANDBY && trig_rise) begin
      burst_clock_en_reg <= 1'b1;
      burst_on_n_reg     <= 1'b1;
    end else if (tick && at_one) begin
      burst_clock_en_reg <= 1'b0;
      burst_on_n_reg     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic load_seen_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_seen_reg <= 1'b0;
    end else begin
      load_seen_reg <= load_fall;
    end
  end

  load_preset_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load_fall |=> count_reg == $past(preset))
    else $error("counter not preset by load");
  load_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load_fall |=> !blocking_reg && !counter_enable_reg)
    else $error("load did not clear blocking or enable");
  count_down_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    tick && !load_fall |=> count_reg == $past(count_reg) - 11'h001)
    else $error("counter did not step down by one");
  no_trig_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_reg == BCC_STANDBY && !trig_rise && !load_fall
    |=> state_reg == BCC_STANDBY)
    else $error("burst started without trigger");
  stop_at_one_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    tick && at_one && !load_fall |=> !burst_clock_en_reg)
    else $error("burst clock not gated at one");
  done_line_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !burst_on_n_reg |-> count_reg == BCC_CNT_RST)
    else $error("burst line low before count ended");
  block_set_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mid_zero && top_zero && state_reg == BCC_COUNT && !load_fall
    |=> blocking_reg)
    else $error("blocking flop not set at terminal count");
  latch_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lo_fall |=> low_byte_reg == $past(data_s2_reg))
    else $error("low byte not latched");
  latch_high_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hi_fall |=> high_byte_reg == $past(data_s2_reg))
    else $error("high byte not latched");
  top_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    blocking_reg && !load_fall |=> top_val == $past(top_val))
    else $error("upper stage moved while blocked");
  trig_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_reg == BCC_STANDBY && trig_rise && !load_fall
    |=> state_reg == BCC_COUNT && burst_clock_en_reg)
    else $error("trigger in standby did not start burst");
  count_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !tick && !load_fall |=> $stable(count_reg))
    else $error("counter moved without a burst pulse");
  byte_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lo_fall && !hi_fall |=> $stable(preset))
    else $error("burst preset changed without a strobe");

  // blocking ahead of the end shows in any burst with a preset of two or more
  burst_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BCC_COUNT ##1 state_reg == BCC_DONE);
  rearm_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BCC_DONE ##1 load_seen_reg);
  trig_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BCC_STANDBY && trig_rise);
  block_early_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    blocking_reg && state_reg == BCC_COUNT && !at_one);
endmodule
`default_nettype wire

//--- dv/bcc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// period generator model
// ------------------------------------------------------------
module bcc_far_model (
  input  wire logic sys_clk,
  output logic      period_pulse
);
  initial period_pulse = 1'b0;

  // two cycles high, then a gap; even a gap of zero leaves one low cycle, so edges stay apart
  task automatic pulse(input int gap);
    @(negedge sys_clk) period_pulse = 1'b1;
    repeat (2) @(negedge sys_clk);
    period_pulse = 1'b0;
    repeat (gap) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- dv/burst_count_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module burst_count_control_tb;
  import bcc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  data_in = 8'h00;
  logic        lo_n = 1'b1;
  logic        hi_n = 1'b1;
  logic        ld_n = 1'b1;
  logic        ext_trig = 1'b0;
  logic        man_trig = 1'b0;
  logic        pulse;
  logic        clk_en;
  logic        on_n;
  logic        blk;
  logic        cnt_en;
  logic [10:0] count;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [15:0] tbl [5] = '{16'hf801, 16'h0802, 16'h0008, 16'ha809,
                           16'hffff};

  always #2 sys_clk = ~sys_clk;

  bcc_burst_ctrl bcc_burst_ctrl_inst (
    .sys_clk                 (sys_clk),
    .rst_n                   (rst_n),
    .data_in                 (data_in),
    .burst_low_byte_strobe_n (lo_n),
    .burst_high_byte_strobe_n(hi_n),
    .counter_load_strobe_n   (ld_n),
    .ext_trigger             (ext_trig),
    .manual_trigger_key      (man_trig),
    .period_pulse            (pulse),
    .burst_clock_en_reg      (clk_en),
    .burst_on_n_reg          (on_n),
    .blocking_reg            (blk),
    .counter_enable_reg      (cnt_en),
    .count_reg               (count)
  );

  bcc_far_model far_inst (
    .sys_clk     (sys_clk),
    .period_pulse(pulse)
  );

  // ------------------------------------------------------------
  // checking and reporting
  // ------------------------------------------------------------
  function automatic logic [10:0] exp_preset(logic [7:0] h, logic [7:0] l);
    return {h[2:0], l};
  endfunction

  task automatic chk1(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk11(string nm, logic [10:0] e, logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ceiling well above the ~30k cycles the bursts need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 50000) begin
      n_fail++;
      $display("BAD cycle_limit expected 0 seen %0d", cycles);
      close_out();
    end
  end

  // ------------------------------------------------------------
  // processor side strobes
  // ------------------------------------------------------------
  task automatic write_byte(logic h, logic [7:0] v);
    @(negedge sys_clk) data_in = v;
    repeat (3) @(negedge sys_clk);
    if (h) hi_n = 1'b0;
    else lo_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    lo_n = 1'b1;
    hi_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic load();
    @(negedge sys_clk) ld_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    ld_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic trigger(logic ext);
    @(negedge sys_clk);
    if (ext) ext_trig = 1'b1;
    else man_trig = 1'b1;
    repeat (3) @(negedge sys_clk);
    ext_trig = 1'b0;
    man_trig = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [10:0] p;
    void'($urandom(49428));
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    chk1("burst_on_n", 1'b1, on_n);
    // no load yet: a trigger must be refused
    trigger(1'b1);
    chk1("clock_en", 1'b0, clk_en);
    chk1("enable", 1'b0, cnt_en);
    // corner presets first; slot 6 reloads without new bytes
    for (int t = 0; t < 8; t++) begin
      if (t != 6) begin
        {hi, lo} = (t < 5) ? tbl[t] : 16'($urandom) & 16'hf9ff;
        if (exp_preset(hi, lo) == 11'h000) lo = 8'h01;
        write_byte(1'b0, lo);
        write_byte(1'b1, hi);
      end
      p = exp_preset(hi, lo);
      load();
      chk11("preset", p, count);
      chk1("blocking", 1'b0, blk);
      chk1("enable", 1'b0, cnt_en);
      chk1("burst_on_n", 1'b1, on_n);
      far_inst.pulse(3);
      chk11("idle_count", p, count);
      trigger(t[0]);
      chk1("clock_en", 1'b1, clk_en);
      chk1("enable", 1'b1, cnt_en);
      for (int k = 1; k <= int'(p); k++) begin
        far_inst.pulse(3 + $urandom_range(5));
        chk11("count", p - 11'(k), count);
      end
      chk1("burst_on_n", 1'b0, on_n);
      chk1("clock_en", 1'b0, clk_en);
      chk1("blocking", 1'b1, blk);
      trigger(~t[0]);
      chk1("clock_en", 1'b0, clk_en);
      far_inst.pulse(3);
      chk11("stopped", 11'h000, count);
    end
    close_out();
  end
endmodule
`default_nettype wire
